// File: lpmr_mode_regs.v
/*
 * Mode register bank of a four-bank low-power DDR memory, with the
 * thermal status, identification, calibration, bank mask, pattern
 * and reset registers, plus the Activate decode.
 * A read answers one cycle after its command; calibration starts,
 * the reset request and the Activate strobe are one-cycle pulses.
 * Assumes the command/address halves arrive together, synchronous to
 * clk, and that the thermal sensor code is synchronous as well.
 */
//
// Contract
// - Thermal register reports a read-only 3-bit refresh-rate code.
// - Update flag sets whenever the rate code changed since last read.
// - Reading the thermal register clears the update flag.
// - Update flag is zero after power-up until a change.
// - Rate bit 2 reads one above 85 degrees.
// - Two read-only revision registers at 06H and 07H.
// - Configuration reads type, density and I/O width fields.
// - Calibration write starts init, long, short or impedance reset.
// - Undefined calibration codes are ignored.
// - Calibration pin tied high disables all calibration commands.
// - Bank mask bits 3:0 block self-refresh per bank.
// - Bank mask bits 7:4 are discarded.
// - Mask applies in self-refresh only; auto-refresh covers all.
// - Addresses 20H and 28H return patterns A and B.
// - Any write to 3FH resets the device.
// - Activate is chip select low, bit 0 low, bit 1 high.
// - Registers reached only by mode register read and write.
// - Writes to read-only registers change nothing.
//
`timescale 1ns/100ps
`include "lpmr_defines.vh"

module lpmr_mode_regs #(
	parameter       ROW_W          = 15,
	parameter [7:0] MAKER_ID       = 8'h5A, // Arbitrary value
	parameter [7:0] REVISION_ONE   = 8'h11, // Arbitrary value
	parameter [7:0] REVISION_TWO   = 8'h22, // Arbitrary value
	parameter [1:0] IO_WIDTH_CODE  = `LPMR_CFG_IO_X16,
	parameter [7:0] PATTERN_A      = 8'h55,
	parameter [7:0] PATTERN_B      = 8'h33
) (
	// Clock and reset
	input  wire             clk,
	input  wire             srst,
	// Command/address bus, both halves of one command
	input  wire             cs_n,
	input  wire [9:0]       ca_rise,
	input  wire [9:0]       ca_fall,
	// Environment
	input  wire [2:0]       temp_rate,
	input  wire             cal_pin_tied_high,
	input  wire             self_refresh_on,
	// Mode register read answer
	output reg              rd_valid,
	output reg  [7:0]       rd_data,
	// Calibration starts
	output reg              cal_init_start,
	output reg              cal_long_start,
	output reg              cal_short_start,
	output reg              cal_reset_start,
	// Device reset request
	output reg              soft_reset,
	// Refresh control
	output reg  [3:0]       refresh_bank_en,
	output reg  [3:0]       bank_mask,
	// Thermal status view
	output reg  [7:0]       thermal_status,
	// Activate decode
	output wire             act_strobe,
	output wire [1:0]       act_bank,
	output wire [ROW_W-1:0] act_row,
	output wire [3:0]       bank_active
);

	// Matches a mode register command in the rising half
	function cmd_is;
		input       sel_n;
		input [3:0] code;
		input [3:0] want;
		begin
			cmd_is = !sel_n && (code == want);
		end
	endfunction

	// True for a code that starts a calibration
	function cal_code_ok;
		input [7:0] code;
		begin
			cal_code_ok = (code == `LPMR_CAL_INIT) ||
				(code == `LPMR_CAL_LONG) ||
				(code == `LPMR_CAL_SHORT) ||
				(code == `LPMR_CAL_RESET);
		end
	endfunction

	// Command strobes
	wire       wr_cmd;
	wire       rd_cmd;
	// Address and data fields of the command
	wire [7:0] reg_addr;
	wire [7:0] wr_value;
	// Address hits, shared by the read path and the write targets
	wire       hit_thermal;
	wire       hit_maker;
	wire       hit_rev_one;
	wire       hit_rev_two;
	wire       hit_config;
	wire       hit_calib;
	wire       hit_bank_mask;
	wire       hit_pattern_a;
	wire       hit_pattern_b;
	wire       hit_soft_reset;
	// Qualified events
	wire       thermal_read;
	wire       rate_changed;
	wire       cal_allowed;
	wire       cal_write;
	wire       mask_write;
	wire       reset_write;
	// Fixed and composed read values
	wire [7:0] config_value;
	wire [7:0] status_value;

	// Held thermal state
	reg  [2:0] rate;
	reg        temp_change_flag;
	// Next values of the read answer
	reg  [7:0] next_rd_data;
	reg        next_rd_valid;
	// Next values of the calibration pulses
	reg        next_cal_init;
	reg        next_cal_long;
	reg        next_cal_short;
	reg        next_cal_reset;
	// Next value of the refresh enables
	reg  [3:0] next_refresh_bank_en;

	// Command decode: writes and reads only via the mode register commands
	assign wr_cmd = cmd_is(cs_n, ca_rise[3:0], `LPMR_CMD_CFG_WRITE);
	assign rd_cmd = cmd_is(cs_n, ca_rise[3:0], `LPMR_CMD_CFG_READ);

	// Address is rising bits 9:4 low, falling bits 1:0 high
	assign reg_addr = {ca_fall[1:0], ca_rise[9:4]};

	// Write data sits in falling bits 9:2
	assign wr_value = ca_fall[9:2];

	// Address hits; each compares against one mapped register
	assign hit_thermal    = (reg_addr == `LPMR_ADDR_THERMAL);
	assign hit_maker      = (reg_addr == `LPMR_ADDR_MAKER);
	assign hit_rev_one    = (reg_addr == `LPMR_ADDR_REV_ONE);
	assign hit_rev_two    = (reg_addr == `LPMR_ADDR_REV_TWO);
	assign hit_config     = (reg_addr == `LPMR_ADDR_CONFIG);
	assign hit_calib      = (reg_addr == `LPMR_ADDR_CALIB);
	assign hit_bank_mask  = (reg_addr == `LPMR_ADDR_BANK_MASK);
	assign hit_pattern_a  = (reg_addr == `LPMR_ADDR_PATTERN_A);
	assign hit_pattern_b  = (reg_addr == `LPMR_ADDR_PATTERN_B);
	assign hit_soft_reset = (reg_addr == `LPMR_ADDR_SOFT_RESET);

	// Thermal register read strobe
	assign thermal_read = rd_cmd && hit_thermal;

	// Sensor code differs from the one held
	assign rate_changed = (temp_rate != rate);

	// Calibration needs a resistor on the calibration pin
	assign cal_allowed = !cal_pin_tied_high;

	// Calibration write with a defined code only
	assign cal_write = wr_cmd && hit_calib && cal_allowed &&
		cal_code_ok(wr_value);

	// Bank mask write; read-only addresses never reach a register
	assign mask_write = wr_cmd && hit_bank_mask;

	// Reset register write, whatever the data
	assign reset_write = wr_cmd && hit_soft_reset;

	// Configuration value: width, density, type
	assign config_value = {IO_WIDTH_CODE, `LPMR_CFG_DENSITY_256,
		`LPMR_CFG_TYPE_S4};

	// Thermal status: flag on top, reserved bits zero, code below
	assign status_value = {temp_change_flag, 4'h0, rate};

	// Refresh rate code tracks the sensor
	always @(posedge clk) begin
		if (srst) begin
			rate <= `LPMR_RATE_RESET;
		end else begin
			rate <= temp_rate;
		end
	end

	// Update flag: a change sets it, a thermal read clears it,
	// and a change in the read cycle wins so it is never lost
	always @(posedge clk) begin
		if (srst) begin
			temp_change_flag <= 1'b0;
		end else if (rate_changed) begin
			temp_change_flag <= 1'b1;
		end else if (thermal_read) begin
			temp_change_flag <= 1'b0;
		end
	end

	// Thermal status mirror, one cycle behind the held state
	always @(posedge clk) begin
		if (srst) begin
			thermal_status <= 8'h00;
		end else begin
			thermal_status <= status_value;
		end
	end

	// Read data selection; unmapped and write-only return zero
	always @* begin
		next_rd_data = 8'h00;
		if (hit_thermal) begin
			next_rd_data = status_value;
		end else if (hit_maker) begin
			next_rd_data = MAKER_ID;
		end else if (hit_rev_one) begin
			next_rd_data = REVISION_ONE;
		end else if (hit_rev_two) begin
			next_rd_data = REVISION_TWO;
		end else if (hit_config) begin
			next_rd_data = config_value;
		end else if (hit_pattern_a) begin
			next_rd_data = PATTERN_A;
		end else if (hit_pattern_b) begin
			next_rd_data = PATTERN_B;
		end
	end

	// Answer strobe follows any read command
	always @* begin
		next_rd_valid = rd_cmd;
	end

	// Read answer register, one cycle after the command
	always @(posedge clk) begin
		if (srst) begin
			rd_valid <= 1'b0;
			rd_data  <= 8'h00;
		end else begin
			rd_valid <= next_rd_valid;
			if (next_rd_valid)
				rd_data <= next_rd_data;
		end
	end

	// Calibration selection; at most one start per accepted write
	always @* begin
		next_cal_init  = 1'b0;
		next_cal_long  = 1'b0;
		next_cal_short = 1'b0;
		next_cal_reset = 1'b0;
		if (cal_write) begin
			if (wr_value == `LPMR_CAL_INIT) begin
				next_cal_init = 1'b1;
			end else if (wr_value == `LPMR_CAL_LONG) begin
				next_cal_long = 1'b1;
			end else if (wr_value == `LPMR_CAL_SHORT) begin
				next_cal_short = 1'b1;
			end else begin
				next_cal_reset = 1'b1;
			end
		end
	end

	// Calibration start pulses, one cycle each
	always @(posedge clk) begin
		if (srst) begin
			cal_init_start  <= 1'b0;
			cal_long_start  <= 1'b0;
			cal_short_start <= 1'b0;
			cal_reset_start <= 1'b0;
		end else begin
			cal_init_start  <= next_cal_init;
			cal_long_start  <= next_cal_long;
			cal_short_start <= next_cal_short;
			cal_reset_start <= next_cal_reset;
		end
	end

	// Bank mask keeps the low nibble only
	always @(posedge clk) begin
		if (srst) begin
			bank_mask <= `LPMR_MASK_RESET;
		end else if (mask_write) begin
			bank_mask <= wr_value[3:0];
		end
	end

	// Refresh bank enables: the mask only counts in self-refresh
	always @* begin
		next_refresh_bank_en = 4'hF;
		if (self_refresh_on)
			next_refresh_bank_en = ~bank_mask;
	end

	// Refresh bank enable register; all banks after reset
	always @(posedge clk) begin
		if (srst) begin
			refresh_bank_en <= 4'hF;
		end else begin
			refresh_bank_en <= next_refresh_bank_en;
		end
	end

	// Reset register: any data value triggers it
	always @(posedge clk) begin
		if (srst) begin
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= reset_write;
		end
	end

	// Writes to read-only addresses reach no register: only calibration,
	// bank mask and reset are write targets above.
	// The vendor test register accepts and drops its data.

	// Activate decode and bank tracking
	lpmr_act_track #(
		.ROW_W (ROW_W)
	) u_act (
		.clk         (clk),
		.srst        (srst),
		.cs_n        (cs_n),
		.ca_rise     (ca_rise),
		.ca_fall     (ca_fall),
		.act_strobe  (act_strobe),
		.act_bank    (act_bank),
		.act_row     (act_row),
		.bank_active (bank_active)
	);

endmodule

// File: lpmr_defines.vh
/*
 * Constants for the mode register bank and the Activate decode.
 * Assumes it is included by its bare name from each design file.
 */
`ifndef LPMR_DEFINES_VH
`define LPMR_DEFINES_VH

// Mode register addresses
`define LPMR_ADDR_THERMAL    8'h04
`define LPMR_ADDR_MAKER      8'h05
`define LPMR_ADDR_REV_ONE    8'h06
`define LPMR_ADDR_REV_TWO    8'h07
`define LPMR_ADDR_CONFIG     8'h08
`define LPMR_ADDR_TEST       8'h09
`define LPMR_ADDR_CALIB      8'h0A
`define LPMR_ADDR_BANK_MASK  8'h10
`define LPMR_ADDR_PATTERN_A  8'h20
`define LPMR_ADDR_PATTERN_B  8'h28
`define LPMR_ADDR_SOFT_RESET 8'h3F

// Command codes on rising-edge bits 3:0 (bit 0 first)
`define LPMR_CMD_CFG_WRITE   4'h0
`define LPMR_CMD_CFG_READ    4'h8
`define LPMR_CMD_PRE         4'hB
`define LPMR_ACT_CODE        2'h2

// Thermal status fields
`define LPMR_FLAG_BIT        7
`define LPMR_HOT_BIT         2
`define LPMR_RATE_LOW_LIMIT  3'h0
`define LPMR_RATE_1X         3'h3
`define LPMR_RATE_RESERVED   3'h4
`define LPMR_RATE_DERATE     3'h6
`define LPMR_RATE_HIGH_LIMIT 3'h7
`define LPMR_RATE_RESET      3'h3

// Calibration codes
`define LPMR_CAL_INIT        8'hFF
`define LPMR_CAL_LONG        8'hAB
`define LPMR_CAL_SHORT       8'h56
`define LPMR_CAL_RESET       8'hC3

// Configuration register fields
`define LPMR_CFG_TYPE_S4     2'h0
`define LPMR_CFG_DENSITY_256 4'h2
`define LPMR_CFG_IO_X32      2'h0
`define LPMR_CFG_IO_X16      2'h1

// Bank mask layout and reset
`define LPMR_BANKS           4
`define LPMR_MASK_RESET      4'h0

`endif

// File: lpmr_act_track.v
/*
 * Activate and Precharge decode with per-bank open tracking.
 * Assumes ca_rise and ca_fall hold the two halves of one command,
 * presented together in the cycle in which chip select is low.
 */
`timescale 1ns/100ps
`include "lpmr_defines.vh"

module lpmr_act_track #(
	parameter ROW_W = 15
) (
	// Clock and reset
	input  wire             clk,
	input  wire             srst,
	// Command/address bus
	input  wire             cs_n,
	input  wire [9:0]       ca_rise,
	input  wire [9:0]       ca_fall,
	// Decoded results
	output reg              act_strobe,
	output reg  [1:0]       act_bank,
	output reg  [ROW_W-1:0] act_row,
	output reg  [3:0]       bank_active
);

	wire act_hit;
	wire pre_hit;
	wire [3:0] bank_sel;

	// Activate is chip select low, bit 0 low, bit 1 high
	assign act_hit = !cs_n && (ca_rise[1:0] == `LPMR_ACT_CODE);
	assign pre_hit = !cs_n && (ca_rise[3:0] == `LPMR_CMD_PRE);
	assign bank_sel = 4'h1 << ca_rise[8:7];

	// Latch the opened bank and row, one-cycle strobe
	always @(posedge clk) begin
		if (srst) begin
			act_strobe <= 1'b0;
			act_bank   <= 2'h0;
			act_row    <= {ROW_W{1'b0}};
		end else begin
			act_strobe <= act_hit;
			if (act_hit) begin
				act_bank <= ca_rise[8:7];
				act_row  <= {ca_rise[6:2], ca_fall};
			end
		end
	end

	// Open on Activate, close on Precharge (bit 4 selects all banks)
	always @(posedge clk) begin
		if (srst) begin
			bank_active <= 4'h0;
		end else if (act_hit) begin
			bank_active <= bank_active | bank_sel;
		end else if (pre_hit) begin
			if (ca_rise[4])
				bank_active <= 4'h0;
			else
				bank_active <= bank_active & ~bank_sel;
		end
	end

endmodule

// File: lpmr_mode_regs_properties.sv
/* Checker on the ports of the mode register bank, bound below.
   Assumes the command layout and codes of lpmr_defines.vh. */
`timescale 1ns/100ps
`include "lpmr_defines.vh"
module lpmr_props (
	// Clock, reset and command bus
	input wire       clk,
	input wire       srst,
	input wire       cs_n,
	input wire [9:0] ca_rise,
	input wire [9:0] ca_fall,
	// Environment
	input wire [2:0] temp_rate,
	input wire       cal_pin_tied_high,
	input wire       self_refresh_on,
	// Device answers
	input wire       rd_valid,
	input wire [7:0] rd_data,
	input wire       cal_init_start,
	input wire       cal_long_start,
	input wire       cal_short_start,
	input wire       cal_reset_start,
	input wire       soft_reset,
	input wire [3:0] refresh_bank_en,
	input wire [3:0] bank_mask,
	input wire [7:0] thermal_status,
	input wire       act_strobe,
	input wire [1:0] act_bank
);
	// Command decode of the sampled bus
	wire [7:0] ma  = {ca_fall[1:0], ca_rise[9:4]};
	wire [7:0] op  = ca_fall[9:2];
	wire       rd  = !cs_n && ca_rise[3:0] == `LPMR_CMD_CFG_READ;
	wire       wr  = !cs_n && ca_rise[3:0] == `LPMR_CMD_CFG_WRITE;
	wire       cw  = wr && ma == `LPMR_ADDR_CALIB;
	wire [3:0] cal = {cal_init_start, cal_long_start, cal_short_start, cal_reset_start};
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// Thermal read with the sensor code steady over two edges
	sequence s_quiet_read;
		rd && ma == `LPMR_ADDR_THERMAL && $stable(temp_rate) ##1 $stable(temp_rate);
	endsequence
	a_status_read: assert property (rd && ma == `LPMR_ADDR_THERMAL |=> rd_valid &&
		rd_data == {thermal_status[7], 4'h0, thermal_status[2:0]}) else $error("status read");
	a_flag_set: assert property (temp_rate != $past(temp_rate) |-> ##[1:3] thermal_status[7])
		else $error("flag not set");
	a_flag_clear: assert property (s_quiet_read |=> !thermal_status[7]) else $error("flag kept");
	a_cal_long: assert property (cw && !cal_pin_tied_high && op == `LPMR_CAL_LONG |=> cal == 4'h4)
		else $error("long calibration");
	a_cal_ignore: assert property (cw && !(op inside {8'hFF, 8'hAB, 8'h56, 8'hC3}) |=> cal == 4'h0)
		else $error("reserved code");
	a_pin_tied: assert property (cal_pin_tied_high |=> cal == 4'h0) else $error("pin tied");
	a_mask_write: assert property (wr && ma == `LPMR_ADDR_BANK_MASK |=> bank_mask == $past(op[3:0]))
		else $error("bank mask");
	a_auto_refresh: assert property (!self_refresh_on |=> refresh_bank_en == 4'hF)
		else $error("refresh banks");
	a_soft_reset: assert property (wr && ma == `LPMR_ADDR_SOFT_RESET |=> soft_reset) else $error("reset");
	a_act_decode: assert property (!cs_n && ca_rise[1:0] == `LPMR_ACT_CODE |=> act_strobe &&
		act_bank == $past(ca_rise[8:7])) else $error("activate");
endmodule
bind lpmr_mode_regs lpmr_props u_props (.*);

// File: lpmr_host.sv
/* Controller model driving the command/address bus.
   Assumes the device registers each answer at the edge taking the command. */
`timescale 1ns/100ps
`include "lpmr_defines.vh"
module lpmr_host #(
	parameter ACT_GAP = 2,
	parameter PRE_GAP = 3
) (
	// Clock and read answer
	input wire       clk,
	input wire       rd_valid,
	input wire [7:0] rd_data,
	// Command bus
	output reg       cs_n,
	output reg [9:0] ca_rise,
	output reg [9:0] ca_fall
);
	// Set while the last thermal read reported the derating code
	reg derate;
	// Idle bus until the first command
	initial begin
		derate = 1'b0;
		cs_n = 1'b1;
		ca_rise = 10'h000;
		ca_fall = 10'h000;
	end
	// One command for one cycle; deselected lines show the inverse
	task issue(input [9:0] r, input [9:0] f);
		begin
			@(posedge clk);
			#1;
			cs_n = 1'b0;
			ca_rise = r;
			ca_fall = f;
			@(posedge clk);
			#1;
			cs_n = 1'b1;
			ca_rise = ~r;
			ca_fall = ~f;
		end
	endtask
	// Register access only by read and write commands
	task cfg_write(input [7:0] ma, input [7:0] op);
		issue({ma[5:0], `LPMR_CMD_CFG_WRITE}, {op, ma[7:6]});
	endtask
	task cfg_read(input [7:0] ma, output [7:0] d);
		begin
			issue({ma[5:0], `LPMR_CMD_CFG_READ}, {8'h00, ma[7:6]});
			d = rd_valid ? rd_data : 8'hXX;
			// Polled thermal code sets the derating; one cycle covers 50 ns
			if (rd_valid && ma == `LPMR_ADDR_THERMAL)
				derate = (rd_data[2:0] == `LPMR_RATE_DERATE);
		end
	endtask
	// Activates spaced apart, each call opening one bank; one more cycle when derated
	task act(input [1:0] b, input [14:0] row);
		begin
			repeat (ACT_GAP + derate) @(posedge clk);
			issue({1'b0, b, row[14:10], 2'b10}, row[9:0]);
		end
	endtask
	// Precharge one bank or all, then keep the precharge period
	task pre(input every, input [1:0] b);
		begin
			issue({1'b0, b, 2'b00, every, `LPMR_CMD_PRE}, 10'h000);
			repeat (PRE_GAP) @(posedge clk);
		end
	endtask
endmodule

// File: lpmr_mode_regs_tb.sv
/* Self-checking bench for the mode register bank.
   Assumes the controller model and the checker are compiled first. */
`timescale 1ns/100ps
`include "lpmr_defines.vh"
module lpmr_mode_regs_tb;
	// Bench signals
	reg         clk;
	reg         srst = 1'b1;
	reg  [2:0]  temp_rate = 3'h3;
	reg         cal_pin_tied_high = 1'b0;
	reg         self_refresh_on = 1'b0;
	wire        cs_n, rd_valid, soft_reset, act_strobe;
	wire        cal_init_start, cal_long_start, cal_short_start, cal_reset_start;
	wire [9:0]  ca_rise, ca_fall;
	wire [7:0]  rd_data, thermal_status;
	wire [3:0]  refresh_bank_en, bank_mask, bank_active;
	wire [1:0]  act_bank;
	wire [14:0] act_row;
	wire [3:0]  cal = {cal_init_start, cal_long_start, cal_short_start, cal_reset_start};
	reg  [7:0]  d;
	integer     i, n_fail = 0, n_compared = 0;
	// Read table {address, value}; identification values are arbitrary
	reg [111:0] tbl = {32'h055A0611, 32'h07220848, 32'h20552833, 16'h3000};
	reg [39:0]  codes = {`LPMR_CAL_INIT, `LPMR_CAL_LONG, `LPMR_CAL_SHORT, `LPMR_CAL_RESET, 8'h12};
	lpmr_host host (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .cs_n(cs_n),
		.ca_rise(ca_rise), .ca_fall(ca_fall));
	lpmr_mode_regs uut (.clk(clk), .srst(srst), .cs_n(cs_n), .ca_rise(ca_rise), .ca_fall(ca_fall),
		.temp_rate(temp_rate), .cal_pin_tied_high(cal_pin_tied_high), .self_refresh_on(self_refresh_on),
		.rd_valid(rd_valid), .rd_data(rd_data), .cal_init_start(cal_init_start),
		.cal_long_start(cal_long_start), .cal_short_start(cal_short_start),
		.cal_reset_start(cal_reset_start), .soft_reset(soft_reset), .refresh_bank_en(refresh_bank_en),
		.bank_mask(bank_mask), .thermal_status(thermal_status), .act_strobe(act_strobe),
		.act_bank(act_bank), .act_row(act_row), .bank_active(bank_active));
	// Clock of 50 ns
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("FAIL %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task rd(input [7:0] ma, input [7:0] exp);
		begin
			host.cfg_read(ma, d);
			chk(d, exp);
		end
	endtask
	task end_of_test;
		begin
			$display("compared %0d failed %0d", n_compared, n_fail);
			if (n_fail == 0 && n_compared > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// Hang guard
	initial begin
		#(50 * 4000);
		n_fail = n_fail + 1;
		end_of_test;
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		#1 srst = 1'b0;
		rd(`LPMR_ADDR_THERMAL, 8'h03);
		for (i = 0; i < 7; i = i + 1)
			rd(tbl[111-16*i -: 8], tbl[103-16*i -: 8]);
		host.cfg_write(`LPMR_ADDR_CONFIG, 8'hFF);
		rd(`LPMR_ADDR_CONFIG, 8'h48);
		for (i = 0; i < 8; i = i + 1) begin
			temp_rate = 3'h7 - i[2:0];
			repeat (3) @(posedge clk);
			#1 chk(thermal_status, {5'h10, temp_rate});
			rd(`LPMR_ADDR_THERMAL, {5'h10, temp_rate});
			rd(`LPMR_ADDR_THERMAL, {5'h00, temp_rate});
		end
		for (i = 0; i < 5; i = i + 1) begin
			host.cfg_write(`LPMR_ADDR_CALIB, codes[39-8*i -: 8]);
			chk(cal, 4'h8 >> i);
		end
		cal_pin_tied_high = 1'b1;
		host.cfg_write(`LPMR_ADDR_CALIB, `LPMR_CAL_LONG);
		chk(cal, 4'h0);
		cal_pin_tied_high = 1'b0;
		host.cfg_write(`LPMR_ADDR_BANK_MASK, 8'hF5);
		chk(bank_mask, 4'h5);
		chk(refresh_bank_en, 4'hF);
		self_refresh_on = 1'b1;
		repeat (2) @(posedge clk);
		#1 chk(refresh_bank_en, 4'hA);
		self_refresh_on = 1'b0;
		host.act(2'h2, 15'h1234);
		chk({act_strobe, act_bank, bank_active}, 7'h64);
		chk(act_row, 15'h1234);
		host.act(2'h1, 15'h7FFF);
		chk({act_bank, bank_active, act_row}, 21'h0B7FFF);
		host.pre(1'b0, 2'h2);
		#1 chk(bank_active, 4'h2);
		host.pre(1'b1, 2'h0);
		#1 chk(bank_active, 4'h0);
		host.cfg_write(`LPMR_ADDR_SOFT_RESET, 8'h00);
		chk(soft_reset, 1'b1);
		end_of_test;
	end
endmodule
